//--- verilog/serial_mem_slave.sv
// Two-wire serial slave front end with its 8192 byte storage array.
//
// Function
// - Hold 8192 bytes of persistent storage.
// - Sample data on clock rise, drive on fall.
// - Only pull data low or release it.
// - Write protect high blocks every array change.
// - Reads work regardless of write protect.
// - Data falling with clock high is start.
// - Stop ends the transfer, return to standby.
// - Eight bits then acknowledge on ninth clock.
// - Transmitter releases data during ninth clock.
// - Stop before acknowledge abandons, enters standby.
// - After not-acknowledge release the bus.
// - First byte: type, select, direction fields.
// - Select bits must equal straps two, one, zero.
// - Eighth address word bit zero writes, one reads.
// - Type or select mismatch: no acknowledge, standby.
// - Write: two address bytes, high first, acknowledged.
// - Acknowledge each write byte after eight bits.
// - Read: shift eight bits, sample master acknowledge.
// - No busy time; new command accepted immediately.
// - Thirteen bit address, upper three bits zero.
// - Increment address per byte, wrap at top.
// - Current read uses pointer after last stop.
// - Random read uses repeated start after address.
`timescale 1ns/100ps
module serial_mem_slave #(
  parameter logic [3:0] DEV_TYPE = 4'hA  // Arbitrary neutral device type code.
) (
  input  wire logic core_clk_in,         // System clock, 125 MHz.
  input  wire logic rst_in,              // Asynchronous reset, active high.
  input  wire logic clk_en_in,           // Freezes all state while low.
  input  wire logic scl_in,              // Serial clock pin level.
  input  wire logic sda_in,              // Serial data pin level.
  output logic      sda_out,             // Serial data drive value, always low.
  output logic      sda_oe_n_out,        // Low while the device pulls data low.
  input  wire logic wp_in,               // Write protect pin level.
  input  wire logic strap_addr_bit0,     // Address strap zero.
  input  wire logic strap_addr_bit1,     // Address strap one.
  input  wire logic strap_addr_bit2,     // Address strap two.
  output logic      busy_out             // High from a start until the device returns to standby.
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_ff;   // Two stage clock synchroniser.
  logic [1:0] sda_sync_ff;   // Two stage data synchroniser.
  logic [1:0] wp_sync_ff;    // Two stage write protect synchroniser.
  logic [1:0] s0_sync_ff;    // Strap zero synchroniser.
  logic [1:0] s1_sync_ff;    // Strap one synchroniser.
  logic [1:0] s2_sync_ff;    // Strap two synchroniser.
  logic       scl_d_ff;      // Previous synchronised clock.
  logic       sda_d_ff;      // Previous synchronised data.

  // Every pin passes two flip-flops before any logic reads it.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      wp_sync_ff  <= 2'h0;
      s0_sync_ff  <= 2'h0;
      s1_sync_ff  <= 2'h0;
      s2_sync_ff  <= 2'h0;
      scl_d_ff    <= 1'h1;
      sda_d_ff    <= 1'h1;
    end
    else if (clk_en_in)
    begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      wp_sync_ff  <= {wp_sync_ff[0], wp_in};
      s0_sync_ff  <= {s0_sync_ff[0], strap_addr_bit0};
      s1_sync_ff  <= {s1_sync_ff[0], strap_addr_bit1};
      s2_sync_ff  <= {s2_sync_ff[0], strap_addr_bit2};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
    end
  end

  // ----------------------------------------------------------------
  // Edge and condition decode
  // ----------------------------------------------------------------
  wire scl_s    = scl_sync_ff[1];             // Synchronised clock level.
  wire sda_s    = sda_sync_ff[1];             // Synchronised data level.
  wire scl_rise = scl_s & ~scl_d_ff;          // Clock rising edge
  wire scl_fall = ~scl_s & scl_d_ff;          // Clock falling edge
  wire start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;  // Start
  wire stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;  // Stop
  wire [2:0] strap_w = {s2_sync_ff[1], s1_sync_ff[1], s0_sync_ff[1]};  // Strap code.

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  serial_mem_pkg::phase_t phase_ff;           // Current protocol phase.
  serial_mem_pkg::phase_t nxt_phase;          // Next protocol phase.
  logic [2:0]  bit_cnt_ff;                    // Bits taken or sent in this byte.
  logic [7:0]  shift_ff;                      // Receive or transmit shift register.
  logic        ack_slot_ff;                   // High from the eighth rise to the ninth fall.
  logic        ack_drv_ff;                    // Device acknowledges this slot.
  logic [12:0] addr_ff;                       // Working memory address.
  logic [12:0] last_ff;                       // Pointer committed at a stop.
  logic        touched_ff;                    // A byte was accessed this transfer.
  logic        ack_hi_ff;                     // Ninth rising edge already seen.
  logic        sda_low_ff;                    // Device pulls data low.
  logic [7:0]  mem [0:serial_mem_pkg::MEM_DEPTH-1];  // Storage array

  // Byte just completed, including the bit on this rising edge.
  wire [7:0] byte_in   = {shift_ff[6:0], sda_s};
  wire       last_bit  = (bit_cnt_ff == serial_mem_pkg::BIT_CNT_LAST);
  wire       byte_done = scl_rise & ~ack_slot_ff & last_bit;
  wire       type_ok   = (byte_in[serial_mem_pkg::TYPE_MSB:serial_mem_pkg::TYPE_LSB]
                          == DEV_TYPE);
  wire       sel_ok    = (byte_in[serial_mem_pkg::SEL_MSB:serial_mem_pkg::SEL_LSB]
                          == strap_w);
  wire       is_read   = byte_in[serial_mem_pkg::DIR_BIT];
  wire [12:0] addr_inc = addr_ff + 13'h0001;  // Wraps past the top
  wire       wr_en     = byte_done & (phase_ff == serial_mem_pkg::ST_WDAT)
                         & ~wp_sync_ff[1];    // Protected bytes dropped
  wire [12:0] last_inc = last_ff + 13'h0001;  // Next location for current read.
  // The ninth clock: its rise carries the answer, its fall ends the byte.
  wire       ack_rise  = scl_rise & ack_slot_ff & ~ack_hi_ff;
  wire       ack_end   = scl_fall & ack_slot_ff & ack_hi_ff;
  wire       rd_next   = ack_end & (phase_ff == serial_mem_pkg::ST_RACK);  // Load next byte.
  wire [7:0] rd_byte   = mem[addr_ff];        // Byte at the working address

  // Next phase, chosen on completed bytes; master acknowledge is handled in the sequencer.
  always_comb
  begin
    nxt_phase = phase_ff;
    if (byte_done)
    begin
      unique case (phase_ff)
        serial_mem_pkg::ST_DEVW:
          // Mismatch is not acknowledged and returns to standby
          nxt_phase = !(type_ok && sel_ok) ? serial_mem_pkg::ST_IDLE :
                      is_read ? serial_mem_pkg::ST_RACK : serial_mem_pkg::ST_ADRH;
        serial_mem_pkg::ST_ADRH: nxt_phase = serial_mem_pkg::ST_ADRL;
        serial_mem_pkg::ST_ADRL: nxt_phase = serial_mem_pkg::ST_WDAT;
        serial_mem_pkg::ST_RDAT: nxt_phase = serial_mem_pkg::ST_RACK;
        default:                 nxt_phase = phase_ff;
      endcase
    end
  end

  // Main sequencer; start and stop override all byte progress.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_ff    <= serial_mem_pkg::ST_IDLE;
      bit_cnt_ff  <= serial_mem_pkg::BIT_CNT_RST;
      shift_ff    <= serial_mem_pkg::BYTE_RST;
      ack_slot_ff <= 1'h0;
      ack_drv_ff  <= 1'h0;
      addr_ff     <= serial_mem_pkg::ADDR_RST;
      last_ff     <= serial_mem_pkg::ADDR_RST;
      touched_ff  <= 1'h0;
      ack_hi_ff   <= 1'h0;
    end
    else if (clk_en_in)
    begin
      if (start_c)
      begin
        // A start is seen at any time, even a repeated one
        phase_ff    <= serial_mem_pkg::ST_DEVW;
        bit_cnt_ff  <= serial_mem_pkg::BIT_CNT_RST;
        ack_slot_ff <= 1'h0;
        ack_hi_ff   <= 1'h0;
        ack_drv_ff  <= 1'h0;
      end
      else if (stop_c)
      begin
        // Stop abandons any byte and goes to standby at once
        phase_ff    <= serial_mem_pkg::ST_IDLE;
        ack_slot_ff <= 1'h0;
        ack_hi_ff   <= 1'h0;
        ack_drv_ff  <= 1'h0;
        touched_ff  <= 1'h0;
        // The working address then holds the current-read location.
        if (touched_ff)
          last_ff <= addr_ff - 13'h0001;  // Last accessed location
        else
          addr_ff <= last_inc;            // Nothing accessed: keep the old pointer.
      end
      else if (phase_ff != serial_mem_pkg::ST_IDLE)
      begin
        phase_ff <= nxt_phase;
        if (scl_rise && !ack_slot_ff && phase_ff != serial_mem_pkg::ST_RACK)
        begin
          shift_ff   <= (phase_ff == serial_mem_pkg::ST_RDAT) ? {shift_ff[6:0], 1'h1}
                                                              : byte_in;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
        if (byte_done)
        begin
          ack_slot_ff <= 1'h1;
          // Receiver acknowledges; protected data still acknowledged
          ack_drv_ff  <= (phase_ff != serial_mem_pkg::ST_RDAT) &&
                         !(phase_ff == serial_mem_pkg::ST_DEVW && !(type_ok && sel_ok));
          if (phase_ff == serial_mem_pkg::ST_ADRH)
            addr_ff[12:8] <= byte_in[serial_mem_pkg::HI_ADDR_MSB:0];
          if (phase_ff == serial_mem_pkg::ST_ADRL)
            addr_ff[7:0] <= byte_in;
          if (phase_ff == serial_mem_pkg::ST_WDAT)
          begin
            addr_ff    <= addr_inc;
            touched_ff <= 1'h1;
          end
        end
        if (ack_rise)
        begin
          // Ninth rise: low asks for more, high releases
          if (phase_ff == serial_mem_pkg::ST_RACK && sda_s)
          begin
            // Not acknowledged: let the line go and wait for stop or start.
            phase_ff    <= serial_mem_pkg::ST_IDLE;
            ack_slot_ff <= 1'h0;
          end
          else
            ack_hi_ff <= 1'h1;
        end
        if (ack_end)
        begin
          // End of the ninth clock: release the line
          ack_slot_ff <= 1'h0;
          ack_hi_ff   <= 1'h0;
          ack_drv_ff  <= 1'h0;
          bit_cnt_ff  <= serial_mem_pkg::BIT_CNT_RST;
        end
        if (rd_next)
        begin
          // Next read byte loaded on the ninth fall; reads ignore protect
          shift_ff   <= rd_byte;
          addr_ff    <= addr_inc;
          touched_ff <= 1'h1;
          phase_ff   <= serial_mem_pkg::ST_RDAT;
        end
      end
    end
  end

  // Array write at the eighth rising edge, no busy period
  always_ff @(posedge core_clk_in)
  begin
    if (clk_en_in && wr_en && !start_c && !stop_c)
      mem[addr_ff] <= byte_in;
  end

  // ----------------------------------------------------------------
  // Data pin driver, updated on falling clock edges and released at start or stop
  // ----------------------------------------------------------------
  // Read bits and acknowledge change on the fall
  // The first bit of a read byte goes out on the same fall that loads it.
  wire nxt_sda_low = rd_next ? ~rd_byte[7] :
                     (ack_slot_ff & ~ack_hi_ff) ? ack_drv_ff :
                     (phase_ff == serial_mem_pkg::ST_RDAT) & ~shift_ff[7];
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      sda_low_ff <= 1'h0;
    else if (clk_en_in)
    begin
      if (start_c || stop_c)
        sda_low_ff <= 1'h0;
      else if (scl_fall)
        sda_low_ff <= nxt_sda_low;
    end
  end

  assign sda_out      = 1'h0;           // Never driven high
  assign sda_oe_n_out = ~sda_low_ff;    // Open drain enable
  assign busy_out     = (phase_ff != serial_mem_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sda_never_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
    sda_out == 1'h0) else $error("data pin driven high");
  chk_drive_on_fall: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $changed(sda_oe_n_out) |-> $past(scl_fall) || $past(start_c) || $past(stop_c))
    else $error("data drive changed off a falling edge");
  chk_stop_standby: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && stop_c && !start_c |=> phase_ff == serial_mem_pkg::ST_IDLE && sda_oe_n_out)
    else $error("stop did not reach standby");
  chk_start_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && start_c |=> phase_ff == serial_mem_pkg::ST_DEVW)
    else $error("start not taken");
  chk_mismatch_nak: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && byte_done && phase_ff == serial_mem_pkg::ST_DEVW && !(type_ok && sel_ok)
    && !start_c && !stop_c |=> !ack_drv_ff && phase_ff == serial_mem_pkg::ST_IDLE)
    else $error("mismatched address acknowledged");
  chk_write_ack: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && byte_done && phase_ff == serial_mem_pkg::ST_WDAT && !start_c && !stop_c
    |=> ack_drv_ff && ack_slot_ff) else $error("write byte not acknowledged");
  chk_protect_block: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && byte_done && phase_ff == serial_mem_pkg::ST_WDAT && wp_sync_ff[1]
    |=> mem[$past(addr_ff)] == $past(rd_byte)) else $error("write while protected");
  chk_addr_wrap: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && wr_en && !start_c && !stop_c && addr_ff == serial_mem_pkg::ADDR_LAST
    |=> addr_ff == 13'h0000) else $error("address did not wrap");
  chk_read_dir: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && byte_done && phase_ff == serial_mem_pkg::ST_DEVW && type_ok && sel_ok
    && !start_c && !stop_c |=> phase_ff == (is_read ? serial_mem_pkg::ST_RACK
    : serial_mem_pkg::ST_ADRH)) else $error("direction misdecoded");
  chk_ack_driven: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && ack_rise && ack_drv_ff |-> !sda_oe_n_out)
    else $error("acknowledge not driven at the ninth rise");
  chk_nak_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && ack_rise && phase_ff == serial_mem_pkg::ST_RACK && sda_s && !start_c && !stop_c
    |=> phase_ff == serial_mem_pkg::ST_IDLE) else $error("bus not released after refusal");
  cov_write: cover property (@(posedge core_clk_in) disable iff (rst_in) wr_en);
  cov_read: cover property (@(posedge core_clk_in) disable iff (rst_in)
    phase_ff == serial_mem_pkg::ST_RDAT);
  cov_protect: cover property (@(posedge core_clk_in) disable iff (rst_in)
    byte_done && phase_ff == serial_mem_pkg::ST_WDAT && wp_sync_ff[1]);
endmodule // serial_mem_slave

//--- verilog/serial_mem_pkg.sv
// Package with the constants of the two-wire serial memory slave.
package serial_mem_pkg;
  // ----------------------------------------------------------------
  // Storage geometry
  // ----------------------------------------------------------------
  localparam int          MEM_DEPTH      = 8192;   // Number of byte locations.
  localparam int          ADDR_W         = 13;     // Width of a memory address.
  localparam logic [12:0] ADDR_LAST      = 13'h1FFF; // Top location before wrap.
  localparam logic [12:0] ADDR_RST       = 13'h0000; // Pointer value after reset.
  // ----------------------------------------------------------------
  // Address word layout
  // ----------------------------------------------------------------
  localparam int          TYPE_MSB       = 7;      // Upper bit of the type field.
  localparam int          TYPE_LSB       = 4;      // Lower bit of the type field.
  localparam int          SEL_MSB        = 3;      // Upper bit of the select field.
  localparam int          SEL_LSB        = 1;      // Lower bit of the select field.
  localparam int          DIR_BIT        = 0;      // Direction bit, one means read.
  localparam int          HI_ADDR_MSB    = 4;      // Upper used bit of the high address byte.
  localparam logic [2:0]  BIT_CNT_LAST   = 3'h7;   // Count of the eighth bit.
  localparam logic [2:0]  BIT_CNT_RST    = 3'h0;   // Bit counter reset value.
  localparam logic [7:0]  BYTE_RST       = 8'h00;  // Shift register reset value.
  // ----------------------------------------------------------------
  // Protocol phases, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,  // Standby, waiting for a start.
    ST_DEVW  = 7'h02,  // Receiving the address word.
    ST_ADRH  = 7'h04,  // Receiving the high address byte.
    ST_ADRL  = 7'h08,  // Receiving the low address byte.
    ST_WDAT  = 7'h10,  // Receiving write data.
    ST_RDAT  = 7'h20,  // Sending read data.
    ST_RACK  = 7'h40   // Sampling the master acknowledge.
  } phase_t;
endpackage : serial_mem_pkg

//--- bench/serial_master_model.sv
// Two-wire bus master model that makes the serial clock and drives the data line.
`timescale 1ns/100ps
module serial_master_model (
  input  wire logic core_clk_in,  // Clock that paces every bus phase.
  input  wire logic sda_in,       // Resolved level of the data line.
  input  wire logic dev_oe_n_in,  // Device data enable, low while it pulls.
  output logic      scl_out,      // Serial clock, made only here.
  output logic      sda_low_out,  // High while the master pulls data low.
  output int        n_glitch_out  // Device drive changes seen with clock high.
);
  logic last_oe_n;                // Device enable one clock ago.
  // ----------------------------------------------------------------
  // Idle bus and watch on the device drive timing
  // ----------------------------------------------------------------
  initial
  begin
    scl_out      = 1'b1;
    sda_low_out  = 1'b0;
    last_oe_n    = 1'b1;
  end
  // Counts device drive changes while the serial clock is high.
  always @(posedge core_clk_in)
  begin
    if (scl_out && (dev_oe_n_in !== last_oe_n))
      n_glitch_out <= n_glitch_out + 1;
    last_oe_n <= dev_oe_n_in;
  end
  // ----------------------------------------------------------------
  // Bus phases, each ending just after a clock edge
  // ----------------------------------------------------------------
  // Quarter of a 128 ns serial period, the nearest whole-clock figure to 125 ns.
  task automatic q();
    repeat (4) @(posedge core_clk_in);
  endtask
  // Start, also usable as a repeated start from a low clock.
  task automatic start_cond();
    sda_low_out <= 1'b0;
    q();
    scl_out <= 1'b1;
    q();
    sda_low_out <= 1'b1;
    q();
    scl_out <= 1'b0;
    q();
  endtask
  // Stop, entered with the clock low; leaves the bus idle.
  task automatic stop_cond();
    sda_low_out <= 1'b1;
    q();
    scl_out <= 1'b1;
    q();
    sda_low_out <= 1'b0;
    q();
  endtask
  // One clock pulse; data set only while the clock is low, line sampled while high.
  task automatic bit_xfer(input logic b, output logic r);
    sda_low_out <= ~b;
    q();
    scl_out <= 1'b1;
    q();
    r = sda_in;
    q();
    scl_out <= 1'b0;
    q();
  endtask
  // Sends a byte MSB first, then frees data for the device acknowledge.
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask
  // Reads a byte, then answers; rel is the line level seen in the answer slot.
  task automatic recv_byte(input logic m_ack, output logic [7:0] d, output logic rel);
    for (int i = 0; i < 8; i++)
    begin
      bit_xfer(1'b1, rel);
      d = {d[6:0], rel};
    end
    bit_xfer(~m_ack, rel);
  endtask
endmodule // serial_master_model

//--- bench/test_serial_mem_slave.sv
// Self-checking bench for the two-wire serial memory slave.
`timescale 1ns/100ps
module test_serial_mem_slave;
  // ----------------------------------------------------------------
  // Constants, signals and case table
  // ----------------------------------------------------------------
  localparam logic [3:0] TYPE_CODE = 4'h6;  // Arbitrary neutral type code.
  localparam logic [2:0] STRAP     = 3'h5;  // Strap levels two, one, zero.
  localparam logic [7:0] WR_WORD   = {TYPE_CODE, STRAP, 1'b0}; // Write address word.
  localparam logic [7:0] RD_WORD   = {TYPE_CODE, STRAP, 1'b1}; // Read address word.
  typedef struct packed {
    logic [3:0] typ;  // Type field sent.
    logic [2:0] sel;  // Select field sent.
    logic       ack;  // Whether the device should answer.
  } row_t;
  row_t rows [5] = '{'{TYPE_CODE, STRAP, 1'b1}, '{4'h2, STRAP, 1'b0},
                     '{TYPE_CODE, 3'h1, 1'b0}, '{TYPE_CODE, 3'h7, 1'b0},
                     '{TYPE_CODE, 3'h4, 1'b0}};
  logic       core_clk;   // 125 MHz bench clock.
  logic       rst;        // Asynchronous reset, active high.
  logic       clk_en;     // Clock enable, low only during the enable test.
  logic       wp;         // Write protect level.
  logic [2:0] strap;      // Address strap levels.
  logic       scl;        // Serial clock from the master.
  logic       m_low;      // Master pulls data low.
  logic       sda_drv;    // Device drive value.
  logic       oe_n;       // Device enable, active low.
  logic       busy;       // Device transfer flag.
  logic       bit_seen;   // Line level of a loose bit.
  int         n_glitch;   // Drive changes seen with clock high.
  int         n_fail;     // Mismatch count.
  int         n_compared; // Comparison count.
  wire logic  sda;        // Data line with its pull-up.
  // Open-drain resolution: anyone pulling wins, else the pull-up.
  assign sda = m_low ? 1'b0 : (oe_n ? 1'b1 : sda_drv);
  serial_mem_slave #(.DEV_TYPE(TYPE_CODE)) i_serial_mem_slave (
    .core_clk_in(core_clk), .rst_in(rst), .clk_en_in(clk_en), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_drv), .sda_oe_n_out(oe_n), .wp_in(wp),
    .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit2(strap[2]), .busy_out(busy));
  serial_master_model i_serial_master_model (
    .core_clk_in(core_clk), .sda_in(sda), .dev_oe_n_in(oe_n), .scl_out(scl),
    .sda_low_out(m_low), .n_glitch_out(n_glitch));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares and counts; a mismatch is reported at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: saw %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // Sends one byte and compares the acknowledge.
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    i_serial_master_model.send_byte(d, a);
    check(16'(a), 16'(exp_ack), "acknowledge");
  endtask
  // Reads one byte, answering acknowledge when m_ack is high.
  task automatic get(input logic m_ack, input logic [7:0] exp);
    logic [7:0] d;
    logic       rel;
    i_serial_master_model.recv_byte(m_ack, d, rel);
    check(16'(d), 16'(exp), "read data");
    check(16'(rel), 16'(!m_ack), "line in answer slot");
  endtask
  // Start, write word and both address bytes, high byte first.
  task automatic set_addr(input logic [12:0] a);
    i_serial_master_model.start_cond();
    send(WR_WORD, 1'b1);
    send({3'h0, a[12:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask
  // Random read of n bytes whose expected values count up from first.
  task automatic rd_at(input logic [12:0] a, input int n, input logic [7:0] first);
    set_addr(a);
    i_serial_master_model.start_cond();
    send(RD_WORD, 1'b1);
    for (int i = 0; i < n; i++)
      get(i < n - 1, first + 8'(i));
    i_serial_master_model.stop_cond();
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Cuts a hang short; the tests need well under a tenth of this span.
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    $display("[FAIL] %0t run did not finish", $time);
    close_out();
  end
  initial
  begin
    rst    = 1'b1;
    clk_en = 1'b1;
    wp     = 1'b0;
    strap  = STRAP;
    repeat (8) @(posedge core_clk);
    check(16'(oe_n), 16'h0001, "enable in reset");
    check(16'(busy), 16'h0000, "busy in reset");
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    $display("reset test done");
    // Clock enable low freezes the block, so a whole frame goes unseen.
    clk_en <= 1'b0;
    i_serial_master_model.start_cond();
    check(16'(busy), 16'h0000, "frozen by clock enable");
    i_serial_master_model.stop_cond();
    clk_en <= 1'b1;
    i_serial_master_model.q();
    check(16'(busy), 16'h0000, "idle after enable");
    $display("enable test done");
    // Address word table: matching word, wrong type and each select bit wrong.
    foreach (rows[i])
    begin
      i_serial_master_model.start_cond();
      send({rows[i].typ, rows[i].sel, 1'b0}, rows[i].ack);
      i_serial_master_model.q();
      check(16'(busy), 16'(rows[i].ack), "standby after word");
      i_serial_master_model.stop_cond();
      i_serial_master_model.q();
      check(16'(busy), 16'h0000, "standby after stop");
      $display("row %0d done", i);
    end
    // Four bytes across the top of the array, read back with wrap.
    set_addr(13'h1FFE);
    for (int i = 0; i < 4; i++)
      send(8'hC0 + 8'(i), 1'b1);
    i_serial_master_model.stop_cond();
    rd_at(13'h1FFE, 3, 8'hC0);
    $display("wrap test done");
    i_serial_master_model.start_cond();
    send(RD_WORD, 1'b1);
    get(1'b0, 8'hC3);
    i_serial_master_model.stop_cond();
    $display("current read test done");
    wp <= 1'b1;
    set_addr(13'h0000);
    send(8'h55, 1'b1);
    i_serial_master_model.stop_cond();
    rd_at(13'h0000, 1, 8'hC2);
    wp <= 1'b0;
    $display("protect test done");
    // Stop after half a data byte leaves the old byte in place.
    set_addr(13'h0001);
    for (int i = 0; i < 4; i++)
      i_serial_master_model.bit_xfer(1'b0, bit_seen);
    i_serial_master_model.stop_cond();
    i_serial_master_model.q();
    check(16'(busy), 16'h0000, "standby after cut byte");
    rd_at(13'h0001, 1, 8'hC3);
    check(16'(sda_drv), 16'h0000, "drive value");
    check(n_glitch[15:0], 16'h0000, "drive change with clock high");
    $display("cut byte test done");
    close_out();
  end
endmodule // test_serial_mem_slave
